// file: pmc_pkg.sv
package pmc_pkg;

    // ==========================================================
    // global modes, gray coded along active -> alt -> sleep -> hibernate
    typedef enum logic [1:0]
    {
        PMC_ACTIVE = 2'h0,
        PMC_ALT_ACTIVE = 2'h1,
        PMC_SLEEP = 2'h3,
        PMC_HIBERNATE = 2'h2
    } pmc_mode_e;

    // ==========================================================
    // subsystem enable positions; cpu and flash sit in fixed places
    localparam int PMC_NSUB = 8;
    localparam int PMC_CPU_BIT = 0;
    localparam int PMC_FLASH_BIT = 1;
    localparam logic [PMC_NSUB-1:0] PMC_TMPL_RST = 8'hFF;
    localparam logic [PMC_NSUB-1:0] PMC_ALT_RST = 8'hFC;

    // ==========================================================
    // resume timing from sleep
    localparam int PMC_CLK_MHZ = 50;
    localparam int PMC_RESUME_US = 15;
    localparam int PMC_RESUME_CYC = PMC_RESUME_US * PMC_CLK_MHZ;
    localparam int PMC_WAKE_CYC = 4;

    // ==========================================================
    // wakeup request bundle
    typedef struct packed
    {
        logic pin_irq;
        logic other_irq;
        logic dev_reset;
    } pmc_wake_s;

    // clock keep-alive bundle: slow, watch and fast clock enables
    typedef struct packed
    {
        logic low_speed_osc_en;
        logic watch_crystal_osc_en;
        logic fast_clk_en;
    } pmc_clk_s;

endpackage

// file: pmc_ctrl.sv
`timescale 1ns/100ps
// Contract
// - exactly four modes, ordered by power draw
// - active template bits enable subsystems in active
// - alternate active uses its own template
// - template changes reach enables one clock later
// - disabled subsystem gets its clock gated
// - cpu may stop itself, wakeup restarts it
// - wakeup forces active mode and cpu on
// - mode resets to active
// - sleep disables all subsystems regardless of template
// - sleep keeps only slow and watch clocks
// - hibernate stops all clocks, state retained
// - hibernate wakes only from pin interrupts
// - alternate active may drop cpu and flash
// - resume from sleep within 15 microseconds
// - interrupt or device reset restores active
module pmc_ctrl
#(
    parameter int NSUB = pmc_pkg::PMC_NSUB
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic mode_wr,
    input wire pmc_pkg::pmc_mode_e mode_wdata,
    input wire logic [NSUB-1:0] act_tmpl,
    input wire logic [NSUB-1:0] alt_tmpl,
    input wire logic cpu_stop,
    input wire pmc_pkg::pmc_wake_s wake_in,
    output pmc_pkg::pmc_mode_e mode,
    output logic [NSUB-1:0] sub_clk_en,
    output pmc_pkg::pmc_clk_s clk_keep,
    output logic cpu_halted,
    output logic resuming
);
    import pmc_pkg::*;

    // ==========================================================
    // parameter check
    if (NSUB < 2)
    begin : g_bad
        $error("pmc_ctrl needs at least cpu and flash subsystems");
    end

    // ==========================================================
    // wake input synchroniser: three stages, pins are asynchronous
    logic [2:0] wk_s1_r;
    logic [2:0] wk_s2_r;
    logic [2:0] wk_s3_r;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wk_s1_r <= 3'h0;
            wk_s2_r <= 3'h0;
            wk_s3_r <= 3'h0;
        end
        else
        begin
            wk_s1_r <= wake_in;
            wk_s2_r <= wk_s1_r;
            wk_s3_r <= wk_s2_r;
        end
    end

    // a wake counts once stages two and three agree high
    wire [2:0] wk_agree = wk_s2_r & wk_s3_r;
    wire wk_pin = wk_agree[2];
    wire wk_any = |wk_agree;
    // hibernate listens to the pin unit only
    wire in_hib = (mode == PMC_HIBERNATE);
    wire wake_ok = in_hib ? wk_pin : wk_any;
    wire sleeping = (mode == PMC_SLEEP) || in_hib;

    // ==========================================================
    // mode register and cpu-stopped flag
    pmc_mode_e mode_nxt;
    logic cpu_off_r;
    logic cpu_off_nxt;
    always_comb
    begin
        mode_nxt = mode;
        if (wake_ok)
        begin
            mode_nxt = PMC_ACTIVE;
        end
        else if (mode_wr && !sleeping)
        begin
            mode_nxt = mode_wdata;
        end
    end
    // wake wins over a stop request in the same cycle
    assign cpu_off_nxt = wake_ok ? 1'b0 : (cpu_stop ? 1'b1 : cpu_off_r);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            mode <= PMC_ACTIVE;
            cpu_off_r <= 1'b0;
        end
        else
        begin
            mode <= mode_nxt;
            cpu_off_r <= cpu_off_nxt;
        end
    end

    // ==========================================================
    // resume pulse stretcher: short fixed settle after wake from sleep or hibernate
    localparam int RCW = $clog2(PMC_WAKE_CYC + 1);
    logic [RCW-1:0] res_cnt_r;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            res_cnt_r <= '0;
        end
        else if (wake_ok && sleeping)
        begin
            res_cnt_r <= RCW'(PMC_WAKE_CYC);
        end
        else if (res_cnt_r != '0)
        begin
            res_cnt_r <= res_cnt_r - 1'b1;
        end
    end

    // ==========================================================
    // enable selection: template per mode, cleared in low power
    logic [NSUB-1:0] en_sel;
    always_comb
    begin
        case (mode)
            PMC_ACTIVE: en_sel = act_tmpl;
            PMC_ALT_ACTIVE: en_sel = alt_tmpl;
            PMC_SLEEP: en_sel = '0;
            PMC_HIBERNATE: en_sel = '0;
            default: en_sel = '0;
        endcase
    end

    // cpu forced on for the cycle a wake lands, per subsystem gate
    logic [NSUB-1:0] en_nxt;
    genvar gi;
    for (gi = 0; gi < NSUB; gi++)
    begin : g_en
        if (gi == PMC_CPU_BIT)
        begin : g_cpu
            assign en_nxt[gi] = wake_ok || (en_sel[gi] && !cpu_off_r && !cpu_stop);
        end
        else
        begin : g_sub
            assign en_nxt[gi] = en_sel[gi] && !wake_ok ? 1'b1 : (en_sel[gi] && !sleeping);
        end
    end

    // ==========================================================
    // registered outputs; one cycle from template to gate
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            sub_clk_en <= '0;
            clk_keep <= '0;
            cpu_halted <= 1'b0;
            resuming <= 1'b0;
        end
        else
        begin
            sub_clk_en <= en_nxt;
            clk_keep.low_speed_osc_en <= (mode_nxt != PMC_HIBERNATE);
            clk_keep.watch_crystal_osc_en <= (mode_nxt != PMC_HIBERNATE);
            clk_keep.fast_clk_en <= (mode_nxt == PMC_ACTIVE) || (mode_nxt == PMC_ALT_ACTIVE);
            cpu_halted <= cpu_off_nxt;
            resuming <= (res_cnt_r != '0);
        end
    end

    // ==========================================================
    // checks
    localparam int RES_MAX = PMC_RESUME_CYC;

    // the edge at which a wake lands already turns the cpu gate back on
    sleep_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_SLEEP && !wake_ok) |=> (sub_clk_en == '0))
        else $error("subsystem enabled while asleep");
    hib_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (in_hib && !wk_pin) |=> (mode == PMC_HIBERNATE))
        else $error("hibernate left without pin wake");
    wake_active_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wake_ok |=> (mode == PMC_ACTIVE) && sub_clk_en[PMC_CPU_BIT])
        else $error("wake did not restore active with cpu");
    act_tmpl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_ACTIVE && mode_nxt == PMC_ACTIVE && !wake_ok)
        |=> sub_clk_en[NSUB-1:1] == $past(act_tmpl[NSUB-1:1]))
        else $error("active template not applied");
    alt_tmpl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_ALT_ACTIVE && !wake_ok)
        |=> sub_clk_en[NSUB-1:1] == $past(alt_tmpl[NSUB-1:1]))
        else $error("alternate template not applied");
    hib_clk_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_HIBERNATE) ##1 (mode == PMC_HIBERNATE)
        |-> !clk_keep.low_speed_osc_en && !clk_keep.fast_clk_en
        && !clk_keep.watch_crystal_osc_en)
        else $error("clock running in hibernate");
    sleep_clk_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_SLEEP) ##1 (mode == PMC_SLEEP)
        |-> clk_keep.low_speed_osc_en && clk_keep.watch_crystal_osc_en && !clk_keep.fast_clk_en)
        else $error("sleep clocks wrong");
    resume_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_SLEEP && wake_ok) |-> ##[1:RES_MAX] (mode == PMC_ACTIVE))
        else $error("resume from sleep too slow");
    cpu_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (cpu_stop && !wake_ok) |=> !sub_clk_en[PMC_CPU_BIT] && cpu_halted)
        else $error("cpu did not stop");

    cover_sleep_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_SLEEP) ##1 (mode == PMC_ACTIVE));
    cover_hib_wake: cover property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_HIBERNATE) ##1 (mode == PMC_ACTIVE));
    cover_alt: cover property (@(posedge sys_clk) disable iff (!rst_n)
        (mode == PMC_ALT_ACTIVE) ##1 (mode == PMC_ALT_ACTIVE));
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import pmc_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic sys_clk;
    logic rst_n;
    logic mode_wr;
    logic cpu_stop;
    pmc_mode_e mode_wdata;
    pmc_mode_e mode;
    logic [7:0] act_tmpl;
    logic [7:0] alt_tmpl;
    logic [7:0] sub_clk_en;
    pmc_wake_s wake_in;
    pmc_clk_s clk_keep;
    logic cpu_halted;
    logic resuming;
    int n_mismatch;
    int comparisons;

    pmc_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .mode_wr(mode_wr),
        .mode_wdata(mode_wdata), .act_tmpl(act_tmpl), .alt_tmpl(alt_tmpl),
        .cpu_stop(cpu_stop), .wake_in(wake_in), .mode(mode), .sub_clk_en(sub_clk_en),
        .clk_keep(clk_keep), .cpu_halted(cpu_halted), .resuming(resuming));

    // 50 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // helpers
    // case equality, so an unknown never counts as a match
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // one-cycle write, then wait out the one-edge lag of the enables
    task automatic set_mode(pmc_mode_e m);
        mode_wdata = m;
        mode_wr = 1'b1;
        cyc(1);
        mode_wr = 1'b0;
        cyc(2);
    endtask

    // hold a wake source until active with the cpu running, bounded by the resume budget
    task automatic wake(logic [2:0] w);
        int i;
        wake_in = w;
        for (i = 0; i < PMC_RESUME_CYC && (mode !== PMC_ACTIVE || cpu_halted !== 1'b0); i++)
            cyc(1);
        if (i == PMC_RESUME_CYC)
        begin
            // a hang counts as a failure and ends the run
            n_mismatch++;
            end_of_test();
        end
        cyc(1);
        wake_in = 3'h0;
        // let the synchroniser drain, so that a following stop is not beaten by the old wake
        cyc(2);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        mode_wr = 1'b0;
        cpu_stop = 1'b0;
        mode_wdata = PMC_ACTIVE;
        act_tmpl = 8'hA5;
        alt_tmpl = 8'h3C;
        wake_in = 3'h0;
        n_mismatch = 0;
        comparisons = 0;
        cyc(5);
        rst_n = 1'b1;
        cyc(2);
        chk("mode", PMC_ACTIVE, mode);
        chk("sub_clk_en", 8'hA5, sub_clk_en);
        chk("clk_keep", 8'h07, clk_keep);
        // template edit while running reaches the enables
        act_tmpl = 8'h5B;
        cyc(2);
        chk("sub_clk_en", 8'h5B, sub_clk_en);
        act_tmpl = 8'hA5;
        // alternate template drops cpu and flash
        set_mode(PMC_ALT_ACTIVE);
        chk("mode", PMC_ALT_ACTIVE, mode);
        chk("sub_clk_en", 8'h3C, sub_clk_en);
        set_mode(PMC_SLEEP);
        chk("mode", PMC_SLEEP, mode);
        chk("sub_clk_en", 8'h00, sub_clk_en);
        chk("clk_keep", 8'h06, clk_keep);
        // writes are refused while asleep
        set_mode(PMC_ACTIVE);
        chk("mode", PMC_SLEEP, mode);
        wake(3'h2);
        chk("resuming", 8'h01, resuming);
        chk("sub_clk_en", 8'hA5, sub_clk_en);
        // cpu stops itself; its clock must be gated
        cpu_stop = 1'b1;
        cyc(1);
        cpu_stop = 1'b0;
        cyc(2);
        chk("cpu_halted", 8'h01, cpu_halted);
        chk("sub_clk_en", 8'hA4, sub_clk_en);
        chk("resuming", 8'h00, resuming);
        wake(3'h1);
        chk("cpu_halted", 8'h00, cpu_halted);
        chk("sub_clk_en", 8'hA5, sub_clk_en);
        set_mode(PMC_HIBERNATE);
        chk("clk_keep", 8'h00, clk_keep);
        chk("sub_clk_en", 8'h00, sub_clk_en);
        // a non-pin source must not wake hibernate
        wake_in = 3'h2;
        cyc(8);
        chk("mode", PMC_HIBERNATE, mode);
        wake_in = 3'h0;
        cyc(1);
        wake(3'h4);
        chk("mode", PMC_ACTIVE, mode);
        chk("resuming", 8'h01, resuming);
        chk("clk_keep", 8'h07, clk_keep);
        end_of_test();
    end
endmodule
